// ===== owrsc_regs.vh
// Purpose: Shared constants for the optical wake relay switch controller.
// Assumes: 100 MHz core clock; HF frequencies carried in kHz.
// Notes:   Counts are derived from times; long counts feed module parameters.
`ifndef OWRSC_REGS_VH
`define OWRSC_REGS_VH
`define OWRSC_CLK_MHZ 100
`define OWRSC_BAUD 19200
`define OWRSC_BIT_CYCLES (`OWRSC_CLK_MHZ * 1000000 / `OWRSC_BAUD)
`define OWRSC_PULSE_US 7500
`define OWRSC_PULSE_CYCLES (`OWRSC_PULSE_US * `OWRSC_CLK_MHZ)
`define OWRSC_SESSION_MS 20
`define OWRSC_SESSION_CYCLES (`OWRSC_SESSION_MS * 1000 * `OWRSC_CLK_MHZ)
`define OWRSC_GAP_US 1000
`define OWRSC_GAP_CYCLES (`OWRSC_GAP_US * `OWRSC_CLK_MHZ)
`define OWRSC_MORSE_UNIT_US 1500
`define OWRSC_MORSE_UNIT_CYCLES (`OWRSC_MORSE_UNIT_US * `OWRSC_CLK_MHZ)
`define OWRSC_WDOG_S 33
`define OWRSC_WDOG_CYCLES (`OWRSC_WDOG_S * 32'd1000000 * `OWRSC_CLK_MHZ)
`define OWRSC_PKT_START 8'h02
`define OWRSC_PKT_END 8'h03
`define OWRSC_PKT_LAST 4'h8
`define OWRSC_OPC_SWITCH_FREQ 8'h01
`define OWRSC_OPC_SWITCH_UNIT 8'h02
`define OWRSC_CRC_POLY 16'h1021
`define OWRSC_CRC_INIT 16'hffff
`define OWRSC_BANDS 4'hb
`define OWRSC_MORSE_OPEN 4'h1
`define OWRSC_MORSE_CLOSE 4'h0
`define OWRSC_MORSE_REJECT 4'h0
`define OWRSC_MORSE_LEN_ONE 3'h1
`define OWRSC_MORSE_LEN_TWO 3'h2
`endif

// ===== owrsc_uart_rx.v
// Purpose: Asynchronous serial byte receiver, 8 data bits, one stop bit.
// Assumes: rx is already synchronised to core_clk and idles high.
// Notes:   A start bit is rechecked at mid-bit so glitches do not frame bytes.
`include "owrsc_regs.vh"
`default_nettype none
module owrsc_uart_rx #(
  parameter [31:0] BIT_CYCLES = `OWRSC_BIT_CYCLES
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       rx,
  output reg        byte_valid,
  output reg  [7:0] byte_data,
  output reg        frame_err,
  output wire       busy
);
  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_START = 2'h1;
  localparam [1:0] S_DATA  = 2'h2;
  localparam [1:0] S_STOP  = 2'h3;
  reg [1:0]  state;
  reg [31:0] cnt;
  reg [2:0]  bitn;
  reg [7:0]  shreg;
  assign busy = (state != S_IDLE);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= S_IDLE;
      cnt        <= 32'h0;
      bitn       <= 3'h0;
      shreg      <= 8'h00;
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
      frame_err  <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          cnt <= 32'h0;
          if (!rx) begin
            state <= S_START;
          end
        end
        S_START: begin
          cnt <= cnt + 32'h1;
          if (cnt == (BIT_CYCLES / 32'h2) - 32'h1) begin
            cnt   <= 32'h0;
            bitn  <= 3'h0;
            state <= rx ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          cnt <= cnt + 32'h1;
          if (cnt == BIT_CYCLES - 32'h1) begin
            cnt   <= 32'h0;
            shreg <= {rx, shreg[7:1]};
            bitn  <= bitn + 3'h1;
            if (bitn == 3'h7) begin
              state <= S_STOP;
            end
          end
        end
        default: begin
          cnt <= cnt + 32'h1;
          if (cnt == BIT_CYCLES - 32'h1) begin
            byte_valid <= 1'b1;
            byte_data  <= shreg;
            frame_err  <= !rx;
            state      <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== owrsc_crc16.v
// Purpose: Byte-wide CRC-16 accumulator over the command body.
// Assumes: One byte per enable pulse; clear has priority.
// Notes:   The whole byte is folded in one cycle to keep the packet path simple.
`include "owrsc_regs.vh"
`default_nettype none
module owrsc_crc16 (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        clear,
  input  wire        en,
  input  wire [7:0]  data,
  output reg  [15:0] crc
);
  reg [15:0] next_crc;
  integer i;
  always @* begin
    next_crc = crc;
    for (i = 0; i < 8; i = i + 1) begin
      if (next_crc[15] ^ data[7 - i]) begin
        next_crc = {next_crc[14:0], 1'b0} ^ `OWRSC_CRC_POLY;
      end else begin
        next_crc = {next_crc[14:0], 1'b0};
      end
    end
  end
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc <= `OWRSC_CRC_INIT;
    end else if (clear) begin
      crc <= `OWRSC_CRC_INIT;
    end else if (en) begin
      crc <= next_crc;
    end
  end
endmodule
`default_nettype wire

// ===== owrsc_ctrl.v
// Purpose: Optical wake, packet check and latching relay control for one unit.
// Assumes: Light detector output arrives on a pin; relay bridge takes two drives.
// Notes:   Sleep is modelled as a state; the watchdog and repeater always run.
// Operation
// - First line activity moves the controller from sleep to awake.
// - The next packet carries the command and frequency deciding open or close.
// - Relay latches, so drive is removed once the switching pulse ends.
// - Closing joins the antenna elements; opening isolates them.
// - Wake-up and packet reception each get 20 ms; after the operation the controller sleeps again.
// - Each switching pulse lasts between 5 and 10 ms.
// - Separate open and close outputs drive the relay bridge.
// - The status lamp flashes Morse dots and dashes for open, close and rejected packets.
// - The four band switches read as one number from 0 to 15.
// - The switch value is a band or a unit address for direct commands.
// - Switch value zero never switches the relay; only repeating and the reject flash for a corrupt or CRC-failing packet remain.
// - Received light is regenerated for the next unit in the chain.
// - The repeater disable jumper stops all outgoing light.
// - The controller sees the inverse of the detected light.
// - One inverted signal feeds both wake detection and the serial receiver.
// - Characters received during wake-up are discarded before the packet.
// - Packet has markers, opcode, two operands, CRC-16; act only on match.
// - Frequency command opens at or above the unit's band, else closes.
// - A 33 s watchdog keeps running and restarts a stuck controller.
`include "owrsc_regs.vh"
`default_nettype none
module owrsc_ctrl #(
  parameter [31:0] BIT_CYCLES        = `OWRSC_BIT_CYCLES,
  parameter [31:0] PULSE_CYCLES      = `OWRSC_PULSE_CYCLES,
  parameter [31:0] SESSION_CYCLES    = `OWRSC_SESSION_CYCLES,
  parameter [31:0] GAP_CYCLES        = `OWRSC_GAP_CYCLES,
  parameter [31:0] MORSE_UNIT_CYCLES = `OWRSC_MORSE_UNIT_CYCLES,
  parameter [31:0] WDOG_CYCLES       = `OWRSC_WDOG_CYCLES
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       light_detect,
  input  wire [3:0] band_select_switch,
  input  wire       repeater_disable_jumper,
  output reg        repeater_emitter,
  output reg        relay_drive_a,
  output reg        relay_drive_b,
  output reg        elements_joined,
  output reg        status_lamp,
  output reg        awake,
  output reg        watchdog_restart
);
  localparam [2:0] ST_SLEEP = 3'h0;
  localparam [2:0] ST_WAKE  = 3'h1;
  localparam [2:0] ST_RECV  = 3'h2;
  localparam [2:0] ST_CHECK = 3'h3;
  localparam [2:0] ST_PULSE = 3'h4;
  localparam [2:0] ST_DONE  = 3'h5;
  // Band edges in kHz; index 0 and unlisted indices hold no band.
  function [15:0] band_edge;
    input [3:0] idx;
    input       upper;
    begin
      case (idx)
        4'h1:    band_edge = upper ? 16'h07d0 : 16'h0708;
        4'h2:    band_edge = upper ? 16'h0fa0 : 16'h0dac;
        4'h3:    band_edge = upper ? 16'h151d : 16'h14d2;
        4'h4:    band_edge = upper ? 16'h1c84 : 16'h1b58;
        4'h5:    band_edge = upper ? 16'h27a6 : 16'h2774;
        4'h6:    band_edge = upper ? 16'h380e : 16'h36b0;
        4'h7:    band_edge = upper ? 16'h46f8 : 16'h4694;
        4'h8:    band_edge = upper ? 16'h53ca : 16'h5208;
        4'h9:    band_edge = upper ? 16'h619e : 16'h613a;
        4'ha:    band_edge = upper ? 16'h7404 : 16'h6d60;
        4'hb:    band_edge = upper ? 16'hd2f0 : 16'hc350;
        default: band_edge = 16'h0000;
      endcase
    end
  endfunction
  function [3:0] band_of;
    input [15:0] freq;
    integer k;
    begin
      band_of = 4'h0;
      for (k = 1; k <= 11; k = k + 1) begin
        if (freq >= band_edge(k[3:0], 1'b0) && freq <= band_edge(k[3:0], 1'b1)) begin
          band_of = k[3:0];
        end
      end
    end
  endfunction
  reg        light_s1, light_s2;
  reg        jmp_s1, jmp_s2;
  reg [3:0]  sw_s1, sw_s2;
  wire       rx;
  wire       byte_valid;
  wire [7:0] byte_data;
  wire       frame_err;
  wire       rx_busy;
  wire [15:0] crc_calc;
  reg [2:0]  state;
  reg [31:0] tmr;
  reg [31:0] sess;
  reg [31:0] wd_cnt;
  reg [3:0]  idx;
  reg [7:0]  opc;
  reg [15:0] op1, op2;
  reg [15:0] crc_rx;
  reg        bad;
  reg        go;
  reg [3:0]  go_pat;
  reg [2:0]  go_len;
  reg [3:0]  m_pat;
  reg [2:0]  m_left;
  reg [31:0] m_tmr;
  reg        act, act_open, rej;
  wire       wd_fire;
  wire       sess_over;
  wire       crc_en;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      light_s1 <= 1'b0;
      light_s2 <= 1'b0;
      jmp_s1   <= 1'b0;
      jmp_s2   <= 1'b0;
      sw_s1    <= 4'h0;
      sw_s2    <= 4'h0;
      repeater_emitter <= 1'b0;
    end else begin
      light_s1 <= light_detect;
      light_s2 <= light_s1;
      jmp_s1   <= repeater_disable_jumper;
      jmp_s2   <= jmp_s1;
      sw_s1    <= band_select_switch;
      sw_s2    <= sw_s1;
      repeater_emitter <= light_s2 & ~jmp_s2;
    end
  end
  assign rx = ~light_s2;
  // Wake detection and the receiver both read rx, as on the board.
  owrsc_uart_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .rx         (rx),
    .byte_valid (byte_valid),
    .byte_data  (byte_data),
    .frame_err  (frame_err),
    .busy       (rx_busy)
  );

  assign crc_en = byte_valid && (state == ST_RECV) && (idx >= 4'h1) && (idx <= 4'h5);

  owrsc_crc16 u_crc (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clear    (state != ST_RECV),
    .en       (crc_en),
    .data     (byte_data),
    .crc      (crc_calc)
  );
  assign wd_fire   = (wd_cnt == WDOG_CYCLES - 32'h1);
  assign sess_over = (sess >= SESSION_CYCLES - 32'h1);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt <= 32'h0;
    end else if (wd_fire) begin
      wd_cnt <= 32'h0;
    end else begin
      wd_cnt <= wd_cnt + 32'h1;
    end
  end

  // Decision on a complete packet.
  always @* begin
    act      = 1'b0;
    act_open = 1'b0;
    rej      = 1'b0;
    if (bad || crc_calc != crc_rx) begin
      rej = 1'b1;
    end else if (sw_s2 == 4'h0) begin
      act = 1'b0;
    end else if (opc == `OWRSC_OPC_SWITCH_FREQ) begin
      if (band_of(op1) == 4'h0 || sw_s2 > `OWRSC_BANDS) begin
        rej = 1'b1;
      end else begin
        act      = 1'b1;
        act_open = (op1 >= band_edge(sw_s2, 1'b0));
      end
    end else if (opc == `OWRSC_OPC_SWITCH_UNIT) begin
      act      = (op1[3:0] == sw_s2);
      act_open = op2[0];
    end else begin
      rej = 1'b1;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state  <= ST_SLEEP;
      tmr    <= 32'h0;
      sess   <= 32'h0;
      idx    <= 4'h0;
      opc    <= 8'h00;
      op1    <= 16'h0000;
      op2    <= 16'h0000;
      crc_rx <= 16'h0000;
      bad    <= 1'b0;
      go     <= 1'b0;
      go_pat <= 4'h0;
      go_len <= 3'h0;
      relay_drive_a    <= 1'b0;
      relay_drive_b    <= 1'b0;
      elements_joined  <= 1'b0;
      awake            <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      go               <= 1'b0;
      watchdog_restart <= 1'b0;
      if (wd_fire && state != ST_SLEEP) begin
        state            <= ST_SLEEP;
        relay_drive_a    <= 1'b0;
        relay_drive_b    <= 1'b0;
        awake            <= 1'b0;
        watchdog_restart <= 1'b1;
      end else begin
        case (state)
          ST_SLEEP: begin
            if (!rx) begin
              state <= ST_WAKE;
              awake <= 1'b1;
              tmr   <= 32'h0;
              sess  <= 32'h0;
            end
          end
          ST_WAKE: begin
            // Bytes decoded here are dropped until the line has been quiet.
            sess <= sess + 32'h1;
            tmr  <= rx ? tmr + 32'h1 : 32'h0;
            if (sess_over) begin
              state <= ST_SLEEP;
              awake <= 1'b0;
            end else if (tmr >= GAP_CYCLES - 32'h1 && !rx_busy) begin
              state <= ST_RECV;
              idx   <= 4'h0;
              sess  <= 32'h0;
              bad   <= 1'b0;
            end
          end
          ST_RECV: begin
            sess <= sess + 32'h1;
            if (sess_over) begin
              state <= ST_SLEEP;
              awake <= 1'b0;
            end else if (byte_valid) begin
              if (idx != 4'h0 || byte_data == `OWRSC_PKT_START) begin
                idx <= idx + 4'h1;
                bad <= bad | frame_err;
              end
              case (idx)
                4'h1:    opc         <= byte_data;
                4'h2:    op1[15:8]   <= byte_data;
                4'h3:    op1[7:0]    <= byte_data;
                4'h4:    op2[15:8]   <= byte_data;
                4'h5:    op2[7:0]    <= byte_data;
                4'h6:    crc_rx[15:8] <= byte_data;
                4'h7:    crc_rx[7:0]  <= byte_data;
                default: opc         <= opc;
              endcase
              if (idx == `OWRSC_PKT_LAST) begin
                state <= ST_CHECK;
                bad   <= bad | frame_err | (byte_data != `OWRSC_PKT_END);
              end
            end
          end
          ST_CHECK: begin
            tmr <= 32'h0;
            if (act) begin
              state           <= ST_PULSE;
              relay_drive_a   <= act_open;
              relay_drive_b   <= !act_open;
              elements_joined <= !act_open;
              go              <= 1'b1;
              go_pat          <= act_open ? `OWRSC_MORSE_OPEN : `OWRSC_MORSE_CLOSE;
              go_len          <= `OWRSC_MORSE_LEN_ONE;
            end else begin
              state  <= ST_DONE;
              go     <= rej;
              go_pat <= `OWRSC_MORSE_REJECT;
              go_len <= `OWRSC_MORSE_LEN_TWO;
            end
          end
          ST_PULSE: begin
            tmr <= tmr + 32'h1;
            if (tmr == PULSE_CYCLES - 32'h1) begin
              relay_drive_a <= 1'b0;
              relay_drive_b <= 1'b0;
              state         <= ST_DONE;
            end
          end
          default: begin
            // The lamp finishes its code before power is dropped.
            if (!go && m_left == 3'h0) begin
              state <= ST_SLEEP;
              awake <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Morse: each symbol is on for one unit (dot) or three (dash), then one unit dark.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      m_pat       <= 4'h0;
      m_left      <= 3'h0;
      m_tmr       <= 32'h0;
      status_lamp <= 1'b0;
    end else if (go) begin
      m_pat       <= go_pat;
      m_left      <= go_len;
      m_tmr       <= 32'h0;
      status_lamp <= 1'b1;
    end else if (m_left != 3'h0) begin
      m_tmr <= m_tmr + 32'h1;
      if (status_lamp) begin
        if (m_tmr == (m_pat[0] ? MORSE_UNIT_CYCLES * 32'h3 : MORSE_UNIT_CYCLES) - 32'h1) begin
          status_lamp <= 1'b0;
          m_tmr       <= 32'h0;
        end
      end else if (m_tmr == MORSE_UNIT_CYCLES - 32'h1) begin
        m_tmr       <= 32'h0;
        m_pat       <= {1'b0, m_pat[3:1]};
        m_left      <= m_left - 3'h1;
        status_lamp <= (m_left > 3'h1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== owrsc_ctrl_checker.sv
// Purpose: Port-level checks for the optical wake relay controller.
// Assumes: One clock domain; nrst is the only reset.
// Notes:   Pulse length is counted in helper logic, not by repetition.
`default_nettype none
module owrsc_ctrl_checker #(
  parameter int PULSE_CYCLES = 40
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       light_detect,
  input wire logic [3:0] band_select_switch,
  input wire logic       repeater_disable_jumper,
  input wire logic       repeater_emitter,
  input wire logic       relay_drive_a,
  input wire logic       relay_drive_b,
  input wire logic       elements_joined,
  input wire logic       status_lamp,
  input wire logic       awake,
  input wire logic       watchdog_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  int   run;
  int   since;
  assign drv = relay_drive_a | relay_drive_b;
  // The repeater pipeline holds reset values for a few edges, so it is judged only after that.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run <= 0;
      since <= 0;
    end else begin
      run <= drv ? run + 1 : 0;
      since <= (since < 4) ? since + 1 : since;
    end
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_light_in_sleep;
    !awake ##1 !awake && $rose(light_detect);
  endsequence
  sequence s_drive_start;
    $rose(drv);
  endsequence
  property p_wake;
    s_light_in_sleep |-> ##[1:3] awake;
  endproperty
  property p_excl;
    !(relay_drive_a && relay_drive_b);
  endproperty
  property p_pulse_len;
    $fell(drv) |-> run == PULSE_CYCLES;
  endproperty
  property p_pulse_max;
    drv |-> run < PULSE_CYCLES;
  endproperty
  property p_drive_awake;
    s_drive_start |-> awake throughout (drv [*4]);
  endproperty
  property p_lamp_awake;
    status_lamp |-> awake;
  endproperty
  property p_zero;
    (band_select_switch == 4'h0) [*4] |-> !drv;
  endproperty
  property p_repeat;
    since > 3 |-> repeater_emitter == ($past(light_detect, 3) && !$past(repeater_disable_jumper, 3));
  endproperty
  property p_join;
    $rose(relay_drive_b) |-> elements_joined;
  endproperty
  property p_split;
    $rose(relay_drive_a) |-> !elements_joined;
  endproperty
  property p_wdog;
    watchdog_restart |=> !awake && !drv;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after light in sleep");
  a_excl: assert property (p_excl) else $error("both relay drives high");
  a_pulse_len: assert property (p_pulse_len) else $error("relay pulse length wrong");
  a_pulse_max: assert property (p_pulse_max) else $error("relay drive held too long");
  a_drive_awake: assert property (p_drive_awake) else $error("drive while asleep");
  a_lamp_awake: assert property (p_lamp_awake) else $error("lamp lit while asleep");
  a_zero: assert property (p_zero) else $error("relay driven with switch zero");
  a_repeat: assert property (p_repeat) else $error("repeater output wrong");
  a_join: assert property (p_join) else $error("close did not join elements");
  a_split: assert property (p_split) else $error("open did not split elements");
  a_wdog: assert property (p_wdog) else $error("watchdog did not restart");
endmodule
bind owrsc_ctrl owrsc_ctrl_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_owrsc_ctrl_checker (
  .core_clk(core_clk),
  .nrst(nrst),
  .light_detect(light_detect),
  .band_select_switch(band_select_switch),
  .repeater_disable_jumper(repeater_disable_jumper),
  .repeater_emitter(repeater_emitter),
  .relay_drive_a(relay_drive_a),
  .relay_drive_b(relay_drive_b),
  .elements_joined(elements_joined),
  .status_lamp(status_lamp),
  .awake(awake),
  .watchdog_restart(watchdog_restart)
);
`default_nettype wire

// ===== owrsc_far_end.sv
// Purpose: Far-end serial light source feeding the controller.
// Assumes: Light on the fibre is a space bit; dark is idle.
// Notes:   The line is left dark between frames, as the real sender does.
`default_nettype none
module owrsc_far_end #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic core_clk,
  output var  logic light_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  initial light_detect = 1'b0;
  task automatic send_bit(input logic b);
    light_detect = ~b;
    repeat (BIT_CYCLES) @(negedge core_clk);
  endtask
  task automatic send_byte(input logic [7:0] b);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      send_bit(b[i]);
    end
    send_bit(1'b1);
  endtask
endmodule
`default_nettype wire

// ===== owrsc_tb.sv
// Purpose: Self-checking bench for the optical wake relay controller.
// Assumes: Short counts: pulse 40, Morse unit 24, watchdog 3000 cycles.
// Notes:   Each case resets first, so the watchdog phase is known.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT     = 16;
  localparam int PULSE   = 40;
  localparam int UNIT    = 24;
  localparam int SESSION = 2000;
  localparam int GAP     = 50;
  localparam int WDOG    = 3000;
  logic       core_clk = 1'b0;
  logic       nrst     = 1'b0;
  logic [3:0] sw       = 4'h0;
  logic       jumper   = 1'b0;
  wire logic  light;
  wire logic  emit;
  wire logic  drv_a;
  wire logic  drv_b;
  wire logic  joined;
  wire logic  lamp;
  wire logic  awake;
  wire logic  wdog;
  int         num_errors = 0;
  int         checks     = 0;
  int         cnt_a, cnt_b, cnt_l, cnt_w;
  always #5 core_clk = ~core_clk;
  owrsc_ctrl #(.BIT_CYCLES(BIT), .PULSE_CYCLES(PULSE), .SESSION_CYCLES(SESSION), .GAP_CYCLES(GAP),
    .MORSE_UNIT_CYCLES(UNIT), .WDOG_CYCLES(WDOG)) i_owrsc_ctrl (
    .core_clk(core_clk),
    .nrst(nrst),
    .light_detect(light),
    .band_select_switch(sw),
    .repeater_disable_jumper(jumper),
    .repeater_emitter(emit),
    .relay_drive_a(drv_a),
    .relay_drive_b(drv_b),
    .elements_joined(joined),
    .status_lamp(lamp),
    .awake(awake),
    .watchdog_restart(wdog)
  );
  owrsc_far_end #(.BIT_CYCLES(BIT)) i_owrsc_far_end (
    .core_clk(core_clk),
    .light_detect(light)
  );
  always @(negedge core_clk) begin
    if (drv_a === 1'b1) cnt_a++;
    if (drv_b === 1'b1) cnt_b++;
    if (lamp === 1'b1) cnt_l++;
    if (wdog === 1'b1) cnt_w++;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [39:0] d);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 39; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  task automatic do_reset();
    @(negedge core_clk);
    nrst = 1'b0;
    cnt_a = 0;
    cnt_b = 0;
    cnt_l = 0;
    cnt_w = 0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
  endtask
  // Wake, quiet gap, one packet, then wait for sleep and judge the whole session.
  task automatic run_case(input logic [3:0] s, input logic [7:0] opc, input logic [15:0] op1, op2,
                          input logic bad, input int ea, eb, el, input logic ej);
    logic [39:0] body;
    logic [71:0] pkt;
    body = {opc, op1, op2};
    pkt = {8'h02, body, crc16(body) ^ {15'h0000, bad}, 8'h03};
    sw = s;
    do_reset();
    i_owrsc_far_end.send_byte(8'h55);
    cmp(awake, 1'b1);
    repeat (100) @(negedge core_clk);
    for (int i = 8; i >= 0; i--) i_owrsc_far_end.send_byte(pkt[i*8 +: 8]);
    for (int k = 0; k < 1500 && awake !== 1'b0; k++) @(negedge core_clk);
    cmp(awake, 1'b0);
    cmp(cnt_a, ea);
    cmp(cnt_b, eb);
    cmp(cnt_l, el);
    cmp(joined, ej);
  endtask
  task automatic t_open();
    run_case(4'h4, 8'h01, 16'h1bee, 16'h0000, 1'b0, PULSE, 0, 3 * UNIT, 1'b0);
  endtask
  task automatic t_close();
    run_case(4'h6, 8'h01, 16'h1bee, 16'h0000, 1'b0, 0, PULSE, UNIT, 1'b1);
  endtask
  task automatic t_edge();
    run_case(4'hb, 8'h01, 16'hc350, 16'h0000, 1'b0, PULSE, 0, 3 * UNIT, 1'b0);
  endtask
  task automatic t_crc();
    run_case(4'h6, 8'h01, 16'h1bee, 16'h0000, 1'b1, 0, 0, 2 * UNIT, 1'b0);
  endtask
  task automatic t_band();
    run_case(4'h4, 8'h01, 16'h2ee0, 16'h0000, 1'b0, 0, 0, 2 * UNIT, 1'b0);
    run_case(4'h4, 8'h07, 16'h1bee, 16'h0000, 1'b0, 0, 0, 2 * UNIT, 1'b0);
  endtask
  task automatic t_zero();
    run_case(4'h0, 8'h01, 16'h1bee, 16'h0000, 1'b0, 0, 0, 0, 1'b0);
  endtask
  task automatic t_unit();
    run_case(4'h5, 8'h02, 16'h0005, 16'h0001, 1'b0, PULSE, 0, 3 * UNIT, 1'b0);
    run_case(4'h5, 8'h02, 16'h0003, 16'h0000, 1'b0, 0, 0, 0, 1'b0);
  endtask
  task automatic t_repeater();
    do_reset();
    fork
      i_owrsc_far_end.send_byte(8'h00);
    join_none
    repeat (20) @(negedge core_clk);
    cmp(emit, 1'b1);
    jumper = 1'b1;
    repeat (10) @(negedge core_clk);
    cmp(emit, 1'b0);
    wait fork;
    jumper = 1'b0;
  endtask
  // The watchdog wraps 3000 cycles after reset; waking late leaves it firing mid-session.
  task automatic t_wdog();
    do_reset();
    repeat (2500) @(negedge core_clk);
    i_owrsc_far_end.send_byte(8'h55);
    repeat (600) @(negedge core_clk);
    cmp(cnt_w, 1);
    cmp(awake, 1'b0);
  endtask
  task automatic results();
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    // The cases need about 20000 cycles together; twice that means a hang.
    #400000;
    num_errors++;
    results();
  end
  initial begin
    t_repeater();
    t_open();
    t_close();
    t_edge();
    t_crc();
    t_band();
    t_zero();
    t_unit();
    t_wdog();
    results();
  end
endmodule
`default_nettype wire
